// *** design/uhie_change_detect.sv ***
// Change detector: flags any difference between a vector and its previous value
`timescale 1ns/100ps
`include "uhie_defs.svh"

module uhie_change_detect
    import uhie_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Observed vector
    input wire logic [WIDTH-1:0] value,
    // Per-bit rise and any-bit change, combinational
    output logic [WIDTH-1:0] rise,
    output logic changed
);

    logic [WIDTH-1:0] prev_q;
    logic primed_q;

    // Previous value; first cycle after reset only primes, so reset itself is no change
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prev_q <= '0;
            primed_q <= 1'b0;
        end else begin
            prev_q <= value;
            primed_q <= 1'b1;
        end
    end

    assign rise = primed_q ? (value & ~prev_q) : '0;
    assign changed = primed_q && (value != prev_q);

endmodule

// *** design/uhie_defs.svh ***
// Register offsets, field positions, reset values and counts for the interrupt event block
`ifndef UHIE_DEFS_SVH
`define UHIE_DEFS_SVH

// ----------------------------------------
// Register offsets (bytes from base address)
// ----------------------------------------
`define UHIE_OFS_EVENT_STATUS 8'h0C
`define UHIE_OFS_EVENT_ENABLE 8'h10

// ----------------------------------------
// Bit positions in the 32-bit registers
// ----------------------------------------
`define UHIE_BIT_MASTER 31
`define UHIE_BIT_OWNER 30
`define UHIE_BIT_ROOT_HUB 6
`define UHIE_BIT_FRAME_WRAP 5
`define UHIE_BIT_FATAL 4
`define UHIE_BIT_RESUME 3
`define UHIE_BIT_FRAME_START 2
`define UHIE_BIT_DONE_QUEUE 1
`define UHIE_BIT_OVERRUN 0
`define UHIE_BIT_FRAME_MSB 15
`define UHIE_LOW_EVENTS 7

// ----------------------------------------
// Internal event vector layout (7 low events plus owner change)
// ----------------------------------------
`define UHIE_EVT_WIDTH 8
`define UHIE_EVT_OWNER 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UHIE_RST_EVENTS 8'h00
`define UHIE_RST_MASTER 1'b0
`define UHIE_RST_WORD 32'h0000_0000
`define UHIE_RST_OVERRUN_CNT 2'h0
`define UHIE_OVERRUN_STEP 2'h1

// ----------------------------------------
// Widths of observed state
// ----------------------------------------
`define UHIE_ROOT_HUB_WIDTH 32
`define UHIE_NUM_PORTS 2
`define UHIE_FRAME_WIDTH 16

`endif

// *** design/uhie_pkg.sv ***
// Types shared by the interrupt event block
package uhie_pkg;

    // Done-queue head writeback handshake
    typedef enum logic [1:0] {
        WB_IDLE,
        WB_WRITING,
        WB_HELD
    } uhie_wb_state_type;

endpackage

// *** design/uhie_sticky_bits.sv ***
// Sticky event bits: hardware sets, software clears by writing one, set beats clear
`timescale 1ns/100ps
`include "uhie_defs.svh"

module uhie_sticky_bits
    import uhie_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Hardware set and software clear strobes
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clear,
    // Stored bits
    output logic [WIDTH-1:0] bits_q
);

    logic [WIDTH-1:0] bits_d;

    // A set in the clearing cycle survives; nothing but a clear drops a bit
    always_comb begin
        bits_d = (bits_q & ~clear) | set;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bits_q <= '0;
        end else begin
            bits_q <= bits_d;
        end
    end

endmodule

// *** design/uhie_top.sv ***
// Interrupt event status and enable registers of the full-speed host controller core
//
// What this block does
// - Set owner-change status bit 30 when software sets owner_change_request (bit 3).
// - Unmasked owner-change status raises the system-management interrupt at once.
// - Without the system-management pin the owner-change bit stays zero forever.
// - Set bit 6 when root hub or any port state register changes.
// - Set bit 5 when frame counter bit 15 toggles or shared frame copy updates.
// - Set bit 4 on non-USB system error; software clears it after controller reset.
// - After a fatal system error, halt list processing and bus signaling.
// - Set bit 3 on device resume onset, not when software commands resume.
// - Set bit 2 at each frame start, together with the SOF token; here also set while halted, when no token goes out.
// - Set bit 1 right after the done-queue head reaches shared memory.
// - No further done-queue writeback while bit 1 is still set.
// - Set bit 0 on schedule overrun, after the shared frame number update.
// - Each schedule overrun increments the two-bit overrun counter, wrapping.
// - Interrupt only when status bit, its enable and master enable are set.
// - Enable write sets bits written one; bits written zero are unchanged.
// - Enable read returns stored enable bits without side effect.
// - Enable bit 31 is the master enable for every event.
// - Enable bit 30 gates owner change; enable bits 6..0 gate matching events.
// - Writing one clears a status bit; writing zero leaves it; no software set.
// - Hardware never clears a status bit; it stays until software clears it.
`timescale 1ns/100ps
`include "uhie_defs.svh"

module uhie_top
    import uhie_pkg::*;
#(
    // Build option: one when the system-management interrupt pin exists
    parameter bit SMI_PIN_PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register access behind the base address
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Command status inputs and overrun count
    input wire logic owner_change_request,
    output logic [1:0] overrun_count,
    // Root hub observation
    input wire logic [`UHIE_ROOT_HUB_WIDTH-1:0] root_hub_state_reg,
    input wire logic [`UHIE_ROOT_HUB_WIDTH-1:0] root_port0_state_reg,
    input wire logic [`UHIE_ROOT_HUB_WIDTH-1:0] root_port1_state_reg,
    // Frame timing
    input wire logic [`UHIE_FRAME_WIDTH-1:0] frame_counter_reg,
    input wire logic shared_frame_counter_updated,
    input wire logic frame_start,
    output logic sof_token_issue,
    input wire logic schedule_overrun,
    // System error and halt
    input wire logic system_error,
    output logic processing_halt,
    // Resume signaling from the bus (asynchronous) and software resume state
    input wire logic device_resume_pin,
    input wire logic bus_resume_state,
    // Done-queue head writeback handshake
    input wire logic done_queue_wb_req,
    input wire logic done_queue_wb_done,
    output logic done_queue_wb_grant,
    // Interrupt requests
    output logic host_irq,
    output logic system_mgmt_irq_pin
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [`UHIE_EVT_WIDTH-1:0] evt_set;
    logic [`UHIE_EVT_WIDTH-1:0] evt_clear;
    logic [`UHIE_EVT_WIDTH-1:0] evt_q;
    logic [`UHIE_EVT_WIDTH-1:0] enable_q;
    logic master_q;
    logic [31:0] status_word;
    logic [31:0] enable_word;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic wr_status;
    logic wr_enable;
    logic resume_meta_q;
    logic resume_sync_q;
    logic [0:0] resume_rise;
    logic [0:0] ocr_rise;
    logic root_hub_changed;
    logic root_port0_changed;
    logic root_port1_changed;
    logic frame_msb_changed;
    logic overrun_pending_q;
    logic [1:0] overrun_cnt_q;
    logic sof_q;
    logic halt_q;
    logic irq_q;
    logic smi_q;
    logic grant_q;
    logic [`UHIE_EVT_WIDTH-1:0] pending;
    uhie_wb_state_type wb_state_q;
    uhie_wb_state_type wb_state_d;

    // ----------------------------------------
    // Register decode
    // ----------------------------------------

    // Write strobes for the two registers; other offsets are ignored
    assign wr_status = reg_wr_en && (reg_addr == `UHIE_OFS_EVENT_STATUS);
    assign wr_enable = reg_wr_en && (reg_addr == `UHIE_OFS_EVENT_ENABLE);

    // Status write of one clears; zero and reserved positions do nothing
    always_comb begin
        evt_clear = '0;
        if (wr_status) begin
            evt_clear[`UHIE_LOW_EVENTS-1:0] = reg_wdata[`UHIE_LOW_EVENTS-1:0];
            evt_clear[`UHIE_EVT_OWNER] = reg_wdata[`UHIE_BIT_OWNER];
        end
    end

    // ----------------------------------------
    // Event sources
    // ----------------------------------------

    // Resume pin comes from the bus, so two flops before any logic looks at it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            resume_meta_q <= 1'b0;
            resume_sync_q <= 1'b0;
        end else begin
            resume_meta_q <= device_resume_pin;
            resume_sync_q <= resume_meta_q;
        end
    end

    uhie_change_detect #(.WIDTH(1)) u_resume_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .value(resume_sync_q),
        .rise(resume_rise),
        .changed()
    );

    uhie_change_detect #(.WIDTH(1)) u_ocr_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .value(owner_change_request),
        .rise(ocr_rise),
        .changed()
    );

    uhie_change_detect #(.WIDTH(`UHIE_ROOT_HUB_WIDTH)) u_hub_change (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .value(root_hub_state_reg),
        .rise(),
        .changed(root_hub_changed)
    );

    uhie_change_detect #(.WIDTH(`UHIE_ROOT_HUB_WIDTH)) u_port0_change (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .value(root_port0_state_reg),
        .rise(),
        .changed(root_port0_changed)
    );

    uhie_change_detect #(.WIDTH(`UHIE_ROOT_HUB_WIDTH)) u_port1_change (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .value(root_port1_state_reg),
        .rise(),
        .changed(root_port1_changed)
    );

    uhie_change_detect #(.WIDTH(1)) u_frame_msb (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .value(frame_counter_reg[`UHIE_BIT_FRAME_MSB]),
        .rise(),
        .changed(frame_msb_changed)
    );

    // Overrun waits for the shared frame copy update before it shows
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            overrun_pending_q <= 1'b0;
        end else if (shared_frame_counter_updated) begin
            overrun_pending_q <= 1'b0;
        end else if (schedule_overrun) begin
            overrun_pending_q <= 1'b1;
        end
    end

    // Overrun counter counts every overrun, set bit or not, and wraps
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            overrun_cnt_q <= `UHIE_RST_OVERRUN_CNT;
        end else if (schedule_overrun) begin
            overrun_cnt_q <= overrun_cnt_q + `UHIE_OVERRUN_STEP;
        end
    end

    // Set vector for the sticky status bits
    always_comb begin
        evt_set = '0;
        evt_set[`UHIE_EVT_OWNER] = SMI_PIN_PRESENT && ocr_rise[0];
        evt_set[`UHIE_BIT_ROOT_HUB] = root_hub_changed || root_port0_changed || root_port1_changed;
        evt_set[`UHIE_BIT_FRAME_WRAP] = frame_msb_changed || shared_frame_counter_updated;
        evt_set[`UHIE_BIT_FATAL] = system_error;
        evt_set[`UHIE_BIT_RESUME] = resume_rise[0] && !bus_resume_state;
        evt_set[`UHIE_BIT_FRAME_START] = frame_start;
        evt_set[`UHIE_BIT_DONE_QUEUE] = done_queue_wb_done && (wb_state_q == WB_WRITING);
        evt_set[`UHIE_BIT_OVERRUN] = (overrun_pending_q || schedule_overrun) && shared_frame_counter_updated;
    end

    // Status bits: only hardware sets and only software clears
    uhie_sticky_bits #(.WIDTH(`UHIE_EVT_WIDTH)) u_status (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set(evt_set),
        .clear(evt_clear),
        .bits_q(evt_q)
    );

    // ----------------------------------------
    // Enable register
    // ----------------------------------------

    // Write-one-to-set; only reset clears an enable bit, so nothing here clears
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            enable_q <= `UHIE_RST_EVENTS;
            master_q <= `UHIE_RST_MASTER;
        end else if (wr_enable) begin
            enable_q[`UHIE_LOW_EVENTS-1:0] <= enable_q[`UHIE_LOW_EVENTS-1:0]
                | reg_wdata[`UHIE_LOW_EVENTS-1:0];
            enable_q[`UHIE_EVT_OWNER] <= enable_q[`UHIE_EVT_OWNER] | reg_wdata[`UHIE_BIT_OWNER];
            master_q <= master_q | reg_wdata[`UHIE_BIT_MASTER];
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------

    // Place the internal bits at their register positions; reserved read zero
    always_comb begin
        status_word = `UHIE_RST_WORD;
        status_word[`UHIE_LOW_EVENTS-1:0] = evt_q[`UHIE_LOW_EVENTS-1:0];
        status_word[`UHIE_BIT_OWNER] = SMI_PIN_PRESENT && evt_q[`UHIE_EVT_OWNER];
        enable_word = `UHIE_RST_WORD;
        enable_word[`UHIE_LOW_EVENTS-1:0] = enable_q[`UHIE_LOW_EVENTS-1:0];
        enable_word[`UHIE_BIT_OWNER] = enable_q[`UHIE_EVT_OWNER];
        enable_word[`UHIE_BIT_MASTER] = master_q;
    end

    // Reads have no side effect; unmapped offsets return zero
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd_en) begin
            case (reg_addr)
                `UHIE_OFS_EVENT_STATUS: rdata_d = status_word;
                `UHIE_OFS_EVENT_ENABLE: rdata_d = enable_word;
                default: rdata_d = `UHIE_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_q <= `UHIE_RST_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // Done-queue writeback control
    // ----------------------------------------

    // Grant only while the done bit is clear; the head is kept until software saves it
    always_comb begin
        wb_state_d = wb_state_q;
        case (wb_state_q)
            WB_IDLE: begin
                if (done_queue_wb_req && !evt_q[`UHIE_BIT_DONE_QUEUE]) begin
                    wb_state_d = WB_WRITING;
                end
            end
            WB_WRITING: begin
                if (done_queue_wb_done) begin
                    wb_state_d = WB_HELD;
                end
            end
            WB_HELD: begin
                if (!evt_q[`UHIE_BIT_DONE_QUEUE]) begin
                    wb_state_d = WB_IDLE;
                end
            end
            default: wb_state_d = WB_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wb_state_q <= WB_IDLE;
            grant_q <= 1'b0;
        end else begin
            wb_state_q <= wb_state_d;
            grant_q <= (wb_state_d == WB_WRITING);
        end
    end

    // ----------------------------------------
    // Frame start token and halt
    // ----------------------------------------

    // Token issue is flopped with the same edge that sets the frame start bit
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sof_q <= 1'b0;
            halt_q <= 1'b0;
        end else begin
            sof_q <= frame_start && !evt_set[`UHIE_BIT_FATAL] && !halt_q;
            halt_q <= evt_q[`UHIE_BIT_FATAL] || system_error;
        end
    end

    // ----------------------------------------
    // Interrupt requests
    // ----------------------------------------

    // Owner change goes to the management interrupt, not the ordinary one
    always_comb begin
        pending = evt_q & enable_q;
        if (SMI_PIN_PRESENT) begin
            pending[`UHIE_EVT_OWNER] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            smi_q <= 1'b0;
        end else begin
            irq_q <= master_q && (|pending);
            smi_q <= SMI_PIN_PRESENT && master_q && evt_q[`UHIE_EVT_OWNER]
                && enable_q[`UHIE_EVT_OWNER];
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata = rdata_q;
    assign overrun_count = overrun_cnt_q;
    assign sof_token_issue = sof_q;
    assign processing_halt = halt_q;
    assign done_queue_wb_grant = grant_q;
    assign host_irq = irq_q;
    assign system_mgmt_irq_pin = smi_q;

endmodule

// *** dv/testbench.sv ***
// Self-checking testbench of the interrupt event block
`timescale 1ns/100ps
`include "uhie_defs.svh"

`define CHK(name, exp, act) begin comparisons++; if ((act) !== (exp)) begin errors++; \
    $display("MISMATCH %s expected %h seen %h", name, exp, act); end end

module testbench;
    logic clk_sys, rst_n, reg_wr_en, reg_rd_en, owner_change_request, shared_frame_counter_updated;
    logic frame_start, schedule_overrun, system_error, device_resume_pin, bus_resume_state;
    logic done_queue_wb_req, done_queue_wb_done, sof_token_issue, processing_halt;
    logic done_queue_wb_grant, host_irq, system_mgmt_irq_pin;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, root_hub_state_reg, root_port0_state_reg, root_port1_state_reg;
    logic [15:0] frame_counter_reg;
    logic [1:0] overrun_count;
    int errors, comparisons, cycles;

    uhie_top u_dut (.*);

    // Copy built without the management pin: owner change must stay invisible there
    logic [31:0] bare_rdata;
    logic bare_mgmt_irq;
    uhie_top #(.SMI_PIN_PRESENT(1'b0)) u_dut_bare (.*, .reg_rdata(bare_rdata), .overrun_count(), .host_irq(),
        .sof_token_issue(), .processing_halt(), .done_queue_wb_grant(), .system_mgmt_irq_pin(bare_mgmt_irq));

    // ----------------------------------------
    // Clock, timeout and closing
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // A hang ends the run as a failure instead of running forever
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Drivers, all called at a falling edge
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Strobe drops a cycle before the next access so no signal is set twice in one step
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        tick(1);
        reg_wr_en = 1'b0;
        tick(1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        reg_addr = a;
        reg_rd_en = 1'b1;
        tick(1);
        reg_rd_en = 1'b0;
        tick(1);
        `CHK("reg_rdata", exp, reg_rdata)
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask

    // Reads the expected status, clears it by writing ones, and checks the request follows
    task automatic take_status(input logic [31:0] exp);
        rd_chk(`UHIE_OFS_EVENT_STATUS, exp);
        `CHK("host_irq", |exp[6:0], host_irq)
        reg_wr(`UHIE_OFS_EVENT_STATUS, exp);
        rd_chk(`UHIE_OFS_EVENT_STATUS, 32'h0000_0000);
        `CHK("host_irq", 1'b0, host_irq)
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset_and_enable();
        rd_chk(`UHIE_OFS_EVENT_STATUS, 32'h0000_0000);
        rd_chk(`UHIE_OFS_EVENT_ENABLE, 32'h0000_0000);
        rd_chk(8'h14, 32'h0000_0000);
        reg_wr(`UHIE_OFS_EVENT_ENABLE, 32'h0000_0005);
        rd_chk(`UHIE_OFS_EVENT_ENABLE, 32'h0000_0005);
        reg_wr(`UHIE_OFS_EVENT_ENABLE, 32'h0000_0002);
        rd_chk(`UHIE_OFS_EVENT_ENABLE, 32'h0000_0007);
        reg_wr(`UHIE_OFS_EVENT_ENABLE, 32'h0000_0078);
        rd_chk(`UHIE_OFS_EVENT_ENABLE, 32'h0000_007F);
        rd_chk(`UHIE_OFS_EVENT_ENABLE, 32'h0000_007F);
    endtask

    task automatic test_master_gate();
        frame_start = 1'b1;
        tick(1);
        `CHK("sof_token_issue", 1'b1, sof_token_issue)
        frame_start = 1'b0;
        tick(3);
        `CHK("host_irq", 1'b0, host_irq)
        reg_wr(`UHIE_OFS_EVENT_STATUS, 32'h0000_0000);
        rd_chk(`UHIE_OFS_EVENT_STATUS, 32'h0000_0004);
        reg_wr(`UHIE_OFS_EVENT_ENABLE, 32'h8000_0000);
        `CHK("host_irq", 1'b1, host_irq)
        take_status(32'h0000_0004);
    endtask

    task automatic test_owner_change();
        owner_change_request = 1'b1;
        tick(3);
        rd_chk(`UHIE_OFS_EVENT_STATUS, 32'h4000_0000);
        `CHK("bare_rdata", 32'h0000_0000, bare_rdata)
        `CHK("system_mgmt_irq_pin", 1'b0, system_mgmt_irq_pin)
        reg_wr(`UHIE_OFS_EVENT_ENABLE, 32'h4000_0000);
        `CHK("system_mgmt_irq_pin", 1'b1, system_mgmt_irq_pin)
        `CHK("bare_mgmt_irq", 1'b0, bare_mgmt_irq)
        `CHK("host_irq", 1'b0, host_irq)
        owner_change_request = 1'b0;
        reg_wr(`UHIE_OFS_EVENT_STATUS, 32'h4000_0000);
        `CHK("system_mgmt_irq_pin", 1'b0, system_mgmt_irq_pin)
        rd_chk(`UHIE_OFS_EVENT_ENABLE, 32'hC000_007F);
    endtask

    task automatic test_hub_and_frame();
        root_port1_state_reg = 32'h0000_0001;
        tick(2);
        take_status(32'h0000_0040);
        root_port0_state_reg = 32'h0000_0002;
        tick(2);
        take_status(32'h0000_0040);
        root_hub_state_reg = 32'h0000_0100;
        tick(2);
        take_status(32'h0000_0040);
        frame_counter_reg = 16'h8000;
        tick(2);
        take_status(32'h0000_0020);
        frame_counter_reg = 16'h8001;
        tick(2);
        rd_chk(`UHIE_OFS_EVENT_STATUS, 32'h0000_0000);
    endtask

    task automatic test_error_and_resume();
        pulse(system_error);
        `CHK("processing_halt", 1'b1, processing_halt)
        frame_start = 1'b1;
        tick(1);
        `CHK("sof_token_issue", 1'b0, sof_token_issue)
        frame_start = 1'b0;
        tick(1);
        take_status(32'h0000_0014);
        `CHK("processing_halt", 1'b0, processing_halt)
        bus_resume_state = 1'b1;
        device_resume_pin = 1'b1;
        tick(6);
        rd_chk(`UHIE_OFS_EVENT_STATUS, 32'h0000_0000);
        device_resume_pin = 1'b0;
        tick(4);
        bus_resume_state = 1'b0;
        tick(1);
        device_resume_pin = 1'b1;
        tick(6);
        take_status(32'h0000_0008);
        device_resume_pin = 1'b0;
    endtask

    task automatic test_done_queue();
        done_queue_wb_req = 1'b1;
        tick(1);
        `CHK("done_queue_wb_grant", 1'b1, done_queue_wb_grant)
        pulse(done_queue_wb_done);
        tick(3);
        `CHK("done_queue_wb_grant", 1'b0, done_queue_wb_grant)
        rd_chk(`UHIE_OFS_EVENT_STATUS, 32'h0000_0002);
        reg_wr(`UHIE_OFS_EVENT_STATUS, 32'h0000_0002);
        for (int i = 0; i < 8 && done_queue_wb_grant !== 1'b1; i++) tick(1);
        `CHK("done_queue_wb_grant", 1'b1, done_queue_wb_grant)
        pulse(done_queue_wb_done);
        done_queue_wb_req = 1'b0;
        take_status(32'h0000_0002);
    endtask

    task automatic test_overrun();
        repeat (3) pulse(schedule_overrun);
        `CHK("overrun_count", 2'h3, overrun_count)
        rd_chk(`UHIE_OFS_EVENT_STATUS, 32'h0000_0000);
        pulse(schedule_overrun);
        `CHK("overrun_count", 2'h0, overrun_count)
        pulse(shared_frame_counter_updated);
        take_status(32'h0000_0021);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_n, reg_wr_en, reg_rd_en, owner_change_request, shared_frame_counter_updated} = 5'h00;
        {frame_start, schedule_overrun, system_error, device_resume_pin, bus_resume_state} = 5'h00;
        {done_queue_wb_req, done_queue_wb_done} = 2'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        {root_hub_state_reg, root_port0_state_reg, root_port1_state_reg} = 96'h0;
        frame_counter_reg = 16'h7FFF;
        tick(8);
        rst_n = 1'b1;
        tick(1);
        test_reset_and_enable();
        test_master_gate();
        test_owner_change();
        test_hub_and_frame();
        test_error_and_resume();
        test_done_queue();
        test_overrun();
        stop_test();
    end
endmodule

// *** dv/uhie_top_properties.sv ***
// Port checker of the interrupt event block, bound to the top module
`timescale 1ns/100ps
`include "uhie_defs.svh"

module uhie_top_properties
    import uhie_pkg::*;
#(
    parameter bit SMI_PIN_PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register access
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // Command status and overrun count
    input wire logic owner_change_request,
    input wire logic [1:0] overrun_count,
    // Root hub observation
    input wire logic [`UHIE_ROOT_HUB_WIDTH-1:0] root_hub_state_reg,
    input wire logic [`UHIE_ROOT_HUB_WIDTH-1:0] root_port0_state_reg,
    input wire logic [`UHIE_ROOT_HUB_WIDTH-1:0] root_port1_state_reg,
    // Frame timing
    input wire logic [`UHIE_FRAME_WIDTH-1:0] frame_counter_reg,
    input wire logic shared_frame_counter_updated,
    input wire logic frame_start,
    input wire logic sof_token_issue,
    input wire logic schedule_overrun,
    // Error, resume and writeback
    input wire logic system_error,
    input wire logic processing_halt,
    input wire logic device_resume_pin,
    input wire logic bus_resume_state,
    input wire logic done_queue_wb_req,
    input wire logic done_queue_wb_done,
    input wire logic done_queue_wb_grant,
    // Interrupt requests
    input wire logic host_irq,
    input wire logic system_mgmt_irq_pin
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_reset_quiet: assert property (
        $rose(rst_n) |=> !host_irq && !system_mgmt_irq_pin && overrun_count == 2'h0)
        else $error("outputs not quiet after reset release");
    chk_sof_with_frame: assert property (
        frame_start && !processing_halt && !system_error |=> sof_token_issue)
        else $error("frame start without token");
    chk_overrun_step: assert property (
        schedule_overrun |=> overrun_count == $past(overrun_count) + 2'h1)
        else $error("overrun count did not step");
    chk_halt_on_error: assert property (
        system_error |=> processing_halt)
        else $error("no halt after system error");
    chk_wb_held_off: assert property (
        $fell(done_queue_wb_grant) |-> !done_queue_wb_grant [*3])
        else $error("writeback granted while done flag set");
    chk_wb_done_drop: assert property (
        done_queue_wb_done && done_queue_wb_grant |=> !done_queue_wb_grant)
        else $error("grant stayed after writeback done");
    chk_rdata_hold: assert property (
        !reg_rd_en |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    chk_unmapped_zero: assert property (
        reg_rd_en && reg_addr != `UHIE_OFS_EVENT_STATUS && reg_addr != `UHIE_OFS_EVENT_ENABLE
        |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    // Enables only clear by reset, so a falling request must follow a status clear write
    chk_irq_fall_cause: assert property (
        $fell(host_irq) |-> $past(reg_wr_en, 2))
        else $error("host interrupt dropped without software clear");
    chk_smi_fall_cause: assert property (
        $fell(system_mgmt_irq_pin) |-> $past(reg_wr_en, 2))
        else $error("management interrupt dropped without software clear");

    // Main scenarios reached
    cover property ($rose(host_irq));
    cover property ($rose(system_mgmt_irq_pin));
    cover property ($fell(done_queue_wb_grant));
    cover property (schedule_overrun && overrun_count == 2'h3);
endmodule

bind uhie_top uhie_top_properties #(.SMI_PIN_PRESENT(SMI_PIN_PRESENT)) u_props (.*);
